// ==== pui_pkg.sv ====
// Constants and types shared by the power-up status indicator block
package pui_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned S_PER_MIN = 60;
    localparam int unsigned READY_TIME_S = 20;
    localparam int unsigned READJ_FIRST_MIN = 2;
    localparam int unsigned READJ_PERIOD_S = 600;
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int unsigned READY_MS = READY_TIME_S * MS_PER_S;
    localparam int unsigned READJ_FIRST_MS = READJ_FIRST_MIN * S_PER_MIN * MS_PER_S;
    localparam int unsigned READJ_PERIOD_MS = READJ_PERIOD_S * MS_PER_S;
    localparam int MS_W = 32;
    localparam int CYC_W = 17;
    localparam logic [MS_W-1:0] MS_ZERO = 32'h0000_0000;
    localparam logic [MS_W-1:0] MS_ONE = 32'h0000_0001;
    localparam logic [MS_W-1:0] MS_MAX = 32'hffff_ffff;
    localparam logic [CYC_W-1:0] CYC_ZERO = 17'h0_0000;
    localparam logic [CYC_W-1:0] CYC_ONE = 17'h0_0001;

    typedef enum logic [2:0] {
        PUI_DIAG_REQ,
        PUI_DIAG_WAIT,
        PUI_FAULT,
        PUI_WAIT_START,
        PUI_SPINUP,
        PUI_LOAD_REQ,
        PUI_LOAD_WAIT,
        PUI_RUN
    } pui_state_t;
endpackage : pui_pkg

// ==== pui_tick_if.sv ====
// Timebase carrier between the divider and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface pui_tick_if;
    logic ms_tick;
    logic blink_on;
    modport src (output ms_tick, output blink_on);
    modport snk (input ms_tick, input blink_on);
endinterface : pui_tick_if
`default_nettype wire

// ==== pui_timebase.sv ====
// Millisecond enable and blink phase divider
`timescale 1ns/1ps
`default_nettype none
module pui_timebase #(
    parameter int unsigned CYC_PER_MS = pui_pkg::CYC_PER_MS,
    parameter int unsigned BLINK_HALF_MS = pui_pkg::BLINK_HALF_MS
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    pui_tick_if.src tb
);
    localparam logic [pui_pkg::CYC_W-1:0] CYC_LAST = pui_pkg::CYC_W'(CYC_PER_MS - 1);
    localparam logic [pui_pkg::MS_W-1:0] BLINK_LAST = pui_pkg::MS_W'(BLINK_HALF_MS - 1);

    logic [pui_pkg::CYC_W-1:0] cyc_ff, nxt_cyc;
    logic [pui_pkg::MS_W-1:0] half_ff, nxt_half;
    logic tick_ff, nxt_tick;
    logic blink_ff, nxt_blink;

    always_comb begin
        nxt_tick = (cyc_ff == CYC_LAST);
        nxt_cyc = nxt_tick ? pui_pkg::CYC_ZERO : cyc_ff + pui_pkg::CYC_ONE;
        nxt_half = half_ff;
        nxt_blink = blink_ff;
        if (tick_ff) begin
            if (half_ff == BLINK_LAST) begin
                nxt_half = pui_pkg::MS_ZERO;
                nxt_blink = ~blink_ff;
            end else begin
                nxt_half = half_ff + pui_pkg::MS_ONE;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cyc_ff <= pui_pkg::CYC_ZERO;
            half_ff <= pui_pkg::MS_ZERO;
            tick_ff <= 1'b0;
            blink_ff <= 1'b0;
        end else begin
            cyc_ff <= nxt_cyc;
            half_ff <= nxt_half;
            tick_ff <= nxt_tick;
            blink_ff <= nxt_blink;
        end
    end

    assign tb.ms_tick = tick_ff;
    assign tb.blink_on = blink_ff;
endmodule : pui_timebase
`default_nettype wire

// ==== pui_powerup_indicator.sv ====
// Power-up sequencer and front-panel status indicator of the disk drive unit
`timescale 1ns/1ps
`default_nettype none
module pui_powerup_indicator #(
    parameter int unsigned CYC_PER_MS = pui_pkg::CYC_PER_MS,
    parameter int unsigned READY_MS = pui_pkg::READY_MS,
    parameter int unsigned READJ_FIRST_MS = pui_pkg::READJ_FIRST_MS,
    parameter int unsigned READJ_PERIOD_MS = pui_pkg::READJ_PERIOD_MS,
    parameter int unsigned BLINK_HALF_MS = pui_pkg::BLINK_HALF_MS
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic START_CMD_MODE_I,
    input wire logic READY_IND_MODE_I,
    input wire logic SCSI_CONNECTED_I,
    input wire logic START_CMD_I,
    input wire logic DIAG_DONE_I,
    input wire logic DIAG_FAULT_I,
    input wire logic SYSINFO_DONE_I,
    input wire logic SEEK_BUSY_I,
    input wire logic READJ_DONE_I,
    output logic DIAG_START_O,
    output logic SPINDLE_ON_O,
    output logic READY_O,
    output logic SYSINFO_LOAD_O,
    output logic READJ_REQ_O,
    output logic DIAG_ERROR_O,
    output logic STATUS_INDICATOR_O
);
    localparam logic [pui_pkg::MS_W-1:0] READY_AT = pui_pkg::MS_W'(READY_MS);
    localparam logic [pui_pkg::MS_W-1:0] READJ_FIRST = pui_pkg::MS_W'(READJ_FIRST_MS);
    localparam logic [pui_pkg::MS_W-1:0] READJ_PERIOD = pui_pkg::MS_W'(READJ_PERIOD_MS);
    localparam logic [pui_pkg::MS_W-1:0] DARK_LEN = pui_pkg::MS_W'(BLINK_HALF_MS);

    pui_tick_if tb ();

    pui_timebase #(
        .CYC_PER_MS(CYC_PER_MS),
        .BLINK_HALF_MS(BLINK_HALF_MS)
    ) u_timebase (
        .clk_i(CLK_I),
        .rstn_i(RESETN_I),
        .tb(tb)
    );

    // Saturating ms step, shared by the up and spin timers
    function automatic logic [pui_pkg::MS_W-1:0] ms_step(input logic [pui_pkg::MS_W-1:0] v, input logic tick);
        ms_step = (tick && v != pui_pkg::MS_MAX) ? v + pui_pkg::MS_ONE : v;
    endfunction : ms_step

    // Sequencer state
    pui_pkg::pui_state_t state_ff, nxt_state;
    logic start_mode_ff, nxt_start_mode;
    logic diag_start_ff, nxt_diag_start;
    logic spindle_ff, nxt_spindle;
    logic ready_ff, nxt_ready;
    logic load_ff, nxt_load;
    logic fault_ff, nxt_fault;
    logic [pui_pkg::MS_W-1:0] up_ms_ff, nxt_up_ms;
    logic [pui_pkg::MS_W-1:0] spin_ms_ff, nxt_spin_ms;

    always_comb begin
        nxt_state = state_ff;
        nxt_start_mode = start_mode_ff;
        nxt_diag_start = 1'b0;
        nxt_spindle = spindle_ff;
        nxt_ready = ready_ff;
        nxt_load = 1'b0;
        nxt_fault = fault_ff;
        nxt_up_ms = ms_step(up_ms_ff, tb.ms_tick);
        // Spin timer runs from reset, so in default mode it measures time since power-on
        nxt_spin_ms = ms_step(spin_ms_ff, tb.ms_tick);
        case (state_ff)
            pui_pkg::PUI_DIAG_REQ: begin
                nxt_start_mode = START_CMD_MODE_I; // Strap caught just after release
                nxt_diag_start = 1'b1;
                nxt_state = pui_pkg::PUI_DIAG_WAIT;
            end
            pui_pkg::PUI_DIAG_WAIT: begin
                if (DIAG_DONE_I) begin
                    if (DIAG_FAULT_I) begin
                        nxt_fault = 1'b1;
                        nxt_state = pui_pkg::PUI_FAULT;
                    end else if (start_mode_ff) begin
                        nxt_state = pui_pkg::PUI_WAIT_START;
                    end else begin
                        nxt_spindle = 1'b1;
                        nxt_state = pui_pkg::PUI_SPINUP;
                    end
                end
            end
            pui_pkg::PUI_FAULT: begin
                // Terminal until reset; spindle left as it was
                nxt_state = pui_pkg::PUI_FAULT;
            end
            pui_pkg::PUI_WAIT_START: begin
                if (START_CMD_I) begin
                    nxt_spindle = 1'b1;
                    nxt_spin_ms = pui_pkg::MS_ZERO;
                    nxt_state = pui_pkg::PUI_SPINUP;
                end
            end
            pui_pkg::PUI_SPINUP: begin
                if (spin_ms_ff >= READY_AT) begin
                    nxt_ready = 1'b1;
                    nxt_state = pui_pkg::PUI_LOAD_REQ;
                end
            end
            pui_pkg::PUI_LOAD_REQ: begin
                nxt_load = 1'b1;
                nxt_state = pui_pkg::PUI_LOAD_WAIT;
            end
            pui_pkg::PUI_LOAD_WAIT: begin
                if (SYSINFO_DONE_I) begin
                    nxt_state = pui_pkg::PUI_RUN;
                end
            end
            pui_pkg::PUI_RUN: begin
                nxt_state = pui_pkg::PUI_RUN;
            end
            default: begin
                nxt_state = pui_pkg::PUI_DIAG_REQ;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_ff <= pui_pkg::PUI_DIAG_REQ;
            start_mode_ff <= 1'b0;
            diag_start_ff <= 1'b0;
            spindle_ff <= 1'b0;
            ready_ff <= 1'b0;
            load_ff <= 1'b0;
            fault_ff <= 1'b0;
            up_ms_ff <= pui_pkg::MS_ZERO;
            spin_ms_ff <= pui_pkg::MS_ZERO;
        end else begin
            state_ff <= nxt_state;
            start_mode_ff <= nxt_start_mode;
            diag_start_ff <= nxt_diag_start;
            spindle_ff <= nxt_spindle;
            ready_ff <= nxt_ready;
            load_ff <= nxt_load;
            fault_ff <= nxt_fault;
            up_ms_ff <= nxt_up_ms;
            spin_ms_ff <= nxt_spin_ms;
        end
    end

    // Readjustment scheduler, deadlines measured from power-on
    logic [pui_pkg::MS_W-1:0] readj_at_ff, nxt_readj_at;
    logic readj_req_ff, nxt_readj_req;
    logic readj_busy_ff, nxt_readj_busy;

    always_comb begin
        nxt_readj_at = readj_at_ff;
        nxt_readj_req = 1'b0;
        nxt_readj_busy = readj_busy_ff;
        if (readj_busy_ff && READJ_DONE_I) begin
            nxt_readj_busy = 1'b0;
        end else if (state_ff == pui_pkg::PUI_RUN && !readj_busy_ff && up_ms_ff >= readj_at_ff) begin
            // Overdue slots collapse into one run, avoiding a burst after a late READY
            nxt_readj_req = 1'b1;
            nxt_readj_busy = 1'b1;
            nxt_readj_at = up_ms_ff + READJ_PERIOD;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            readj_at_ff <= READJ_FIRST;
            readj_req_ff <= 1'b0;
            readj_busy_ff <= 1'b0;
        end else begin
            readj_at_ff <= nxt_readj_at;
            readj_req_ff <= nxt_readj_req;
            readj_busy_ff <= nxt_readj_busy;
        end
    end

    // Indicator drive
    logic seek_prev_ff, nxt_seek_prev;
    logic [pui_pkg::MS_W-1:0] dark_ms_ff, nxt_dark_ms;
    logic ind_ff, nxt_ind;

    always_comb begin
        nxt_seek_prev = SEEK_BUSY_I;
        nxt_dark_ms = dark_ms_ff;
        if (SEEK_BUSY_I && !seek_prev_ff) begin
            nxt_dark_ms = DARK_LEN;
        end else if (tb.ms_tick && dark_ms_ff != pui_pkg::MS_ZERO) begin
            nxt_dark_ms = dark_ms_ff - pui_pkg::MS_ONE;
        end
        if (fault_ff) begin
            nxt_ind = tb.blink_on;
        end else if (!READY_IND_MODE_I) begin
            nxt_ind = SCSI_CONNECTED_I;
        end else if (readj_busy_ff) begin
            nxt_ind = tb.blink_on;
        end else begin
            nxt_ind = ready_ff && dark_ms_ff == pui_pkg::MS_ZERO;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            seek_prev_ff <= 1'b0;
            dark_ms_ff <= pui_pkg::MS_ZERO;
            ind_ff <= 1'b0;
        end else begin
            seek_prev_ff <= nxt_seek_prev;
            dark_ms_ff <= nxt_dark_ms;
            ind_ff <= nxt_ind;
        end
    end

    assign DIAG_START_O = diag_start_ff;
    assign SPINDLE_ON_O = spindle_ff;
    assign READY_O = ready_ff;
    assign SYSINFO_LOAD_O = load_ff;
    assign READJ_REQ_O = readj_req_ff;
    assign DIAG_ERROR_O = fault_ff;
    assign STATUS_INDICATOR_O = ind_ff;
endmodule : pui_powerup_indicator
`default_nettype wire

// ==== pui_drive_model.sv ====
// Drive mechanics model answering the sequencer requests
`timescale 1ns/1ps
`default_nettype none
module pui_drive_model (
    input wire logic clk_i,
    input wire logic fault_i,
    input wire logic diag_start_i,
    input wire logic sysinfo_load_i,
    input wire logic readj_req_i,
    output logic diag_done_o,
    output logic diag_fault_o,
    output logic sysinfo_done_o,
    output logic readj_done_o
);
    int wait_q = 0;
    initial begin
        {diag_done_o, diag_fault_o, sysinfo_done_o, readj_done_o} = 4'h0;
    end
    always @(negedge clk_i) begin
        diag_done_o <= diag_start_i;
        // Fault flag only valid with done, so it toggles otherwise
        diag_fault_o <= diag_start_i ? fault_i : ~diag_fault_o;
        sysinfo_done_o <= sysinfo_load_i;
        readj_done_o <= (wait_q == 1);
        wait_q <= readj_req_i ? 20 : (wait_q != 0 ? wait_q - 1 : 0);
    end
endmodule : pui_drive_model
`default_nettype wire

// ==== pui_powerup_indicator_chk.sv ====
// Port assertions for the power-up sequencer and indicator
`timescale 1ns/1ps
`default_nettype none
module pui_powerup_indicator_chk #(
    parameter int unsigned CYC_PER_MS = pui_pkg::CYC_PER_MS,
    parameter int unsigned READY_MS = pui_pkg::READY_MS
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic START_CMD_I,
    input wire logic DIAG_DONE_I,
    input wire logic DIAG_FAULT_I,
    input wire logic READY_IND_MODE_I,
    input wire logic SCSI_CONNECTED_I,
    input wire logic DIAG_START_O,
    input wire logic SPINDLE_ON_O,
    input wire logic READY_O,
    input wire logic SYSINFO_LOAD_O,
    input wire logic READJ_REQ_O,
    input wire logic DIAG_ERROR_O,
    input wire logic STATUS_INDICATOR_O
);
    logic [31:0] cyc_ff;
    logic [31:0] nxt_cyc;
    always_comb begin
        nxt_cyc = (cyc_ff == 32'hffff_ffff) ? cyc_ff : cyc_ff + 32'h0000_0001;
    end
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cyc_ff <= 32'h0000_0000;
        end else begin
            cyc_ff <= nxt_cyc;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    a_diag_first: assert property (DIAG_START_O |-> !SPINDLE_ON_O && !READY_O)
        else $error("diagnosis start after spin-up");
    a_fault_entry: assert property ($rose(DIAG_ERROR_O) |-> $past(DIAG_DONE_I) && $past(DIAG_FAULT_I))
        else $error("error flag without faulty diagnosis");
    a_fault_halts: assert property (DIAG_ERROR_O |-> !SPINDLE_ON_O && !READY_O)
        else $error("sequence went on after fault");
    a_conn_follow: assert property (!READY_IND_MODE_I && !DIAG_ERROR_O |=>
        DIAG_ERROR_O || STATUS_INDICATOR_O == $past(SCSI_CONNECTED_I))
        else $error("indicator not following connection");
    a_ready_time: assert property ($rose(READY_O) |-> cyc_ff >= READY_MS * CYC_PER_MS)
        else $error("ready too early");
    a_ready_spin: assert property ($rose(READY_O) |-> SPINDLE_ON_O)
        else $error("ready without spindle");
    a_load_after: assert property ($rose(READY_O) |=> SYSINFO_LOAD_O ##1 !SYSINFO_LOAD_O)
        else $error("system info load not pulsed after ready");
    a_readj_pulse: assert property (READJ_REQ_O |-> READY_O ##1 !READJ_REQ_O)
        else $error("readjust request malformed");
    a_spin_cause: assert property ($rose(SPINDLE_ON_O) |-> $past(DIAG_DONE_I) || $past(START_CMD_I))
        else $error("spindle started without cause");
endmodule : pui_powerup_indicator_chk
bind pui_powerup_indicator pui_powerup_indicator_chk #(.CYC_PER_MS(CYC_PER_MS), .READY_MS(READY_MS)) chk_i (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .START_CMD_I(START_CMD_I), .DIAG_DONE_I(DIAG_DONE_I),
    .DIAG_FAULT_I(DIAG_FAULT_I), .READY_IND_MODE_I(READY_IND_MODE_I), .SCSI_CONNECTED_I(SCSI_CONNECTED_I),
    .DIAG_START_O(DIAG_START_O), .SPINDLE_ON_O(SPINDLE_ON_O), .READY_O(READY_O), .SYSINFO_LOAD_O(SYSINFO_LOAD_O),
    .READJ_REQ_O(READJ_REQ_O), .DIAG_ERROR_O(DIAG_ERROR_O), .STATUS_INDICATOR_O(STATUS_INDICATOR_O));
`default_nettype wire

// ==== test_powerup_status_indicator.sv ====
// Self-checking bench for the power-up sequencer and indicator
`timescale 1ns/1ps
`default_nettype none
module test_powerup_status_indicator;
    localparam int CPM = 4;
    localparam int RDY = 5;
    localparam int BH = 2;
    logic CLK_I = 1'b0;
    logic RESETN_I = 1'b0;
    logic smode = 1'b0, imode = 1'b0, conn = 1'b0, start = 1'b0, seek = 1'b0, flt = 1'b0;
    logic dd, df, sd, rd, ds, sp, rdy, sl, rq, de, ind;
    int bad_count = 0, checks = 0, cyc = 0;
    always #4 CLK_I = ~CLK_I;
    always @(posedge CLK_I) cyc <= RESETN_I ? cyc + 1 : 0;
    pui_powerup_indicator #(.CYC_PER_MS(CPM), .READY_MS(RDY), .READJ_FIRST_MS(20), .READJ_PERIOD_MS(10),
        .BLINK_HALF_MS(BH)) pui_powerup_indicator_i (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
        .START_CMD_MODE_I(smode), .READY_IND_MODE_I(imode), .SCSI_CONNECTED_I(conn), .START_CMD_I(start),
        .DIAG_DONE_I(dd), .DIAG_FAULT_I(df), .SYSINFO_DONE_I(sd), .SEEK_BUSY_I(seek), .READJ_DONE_I(rd),
        .DIAG_START_O(ds), .SPINDLE_ON_O(sp), .READY_O(rdy), .SYSINFO_LOAD_O(sl), .READJ_REQ_O(rq),
        .DIAG_ERROR_O(de), .STATUS_INDICATOR_O(ind));
    pui_drive_model pui_drive_model_i (.clk_i(CLK_I), .fault_i(flt), .diag_start_i(ds), .sysinfo_load_i(sl),
        .readj_req_i(rq), .diag_done_o(dd), .diag_fault_o(df), .sysinfo_done_o(sd), .readj_done_o(rd));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic do_reset(input logic s, input logic f);
        @(negedge CLK_I);
        {RESETN_I, smode, flt, imode, conn, seek} = {1'b0, s, f, 3'h0};
        repeat (2) @(negedge CLK_I);
        RESETN_I = 1'b1;
        @(negedge CLK_I);
    endtask : do_reset
    task automatic wait_ready(output int n);
        for (n = 0; n < 400 && rdy !== 1'b1; n++) @(negedge CLK_I);
    endtask : wait_ready
    task automatic t_default;
        int n;
        logic [1:0] saw;
        do_reset(1'b0, 1'b0);
        check(ds, 1);
        conn = 1'b1;
        @(negedge CLK_I);
        check(ind, 1);
        conn = 1'b0;
        @(negedge CLK_I);
        check(ind, 0);
        wait_ready(n);
        check(cyc > RDY * CPM && cyc < RDY * CPM + 8, 1);
        @(negedge CLK_I);
        check(sl, 1);
        imode = 1'b1;
        @(negedge CLK_I);
        check(ind, 1);
        seek = 1'b1;
        repeat (2) @(negedge CLK_I);
        check(ind, 0);
        repeat (BH * CPM + 3) @(negedge CLK_I);
        check(ind, 1);
        seek = 1'b0;
        for (n = 0; n < 200 && rq !== 1'b1; n++) @(negedge CLK_I);
        check(cyc > 20 * CPM && cyc < 20 * CPM + 6, 1);
        saw = 2'h0;
        repeat (18) begin
            @(negedge CLK_I);
            saw[ind === 1'b1] = 1'b1;
        end
        check(saw, 2'h3);
        $display("default sequence test done");
    endtask : t_default
    task automatic t_fault;
        int n;
        do_reset(1'b0, 1'b1);
        repeat (3) @(negedge CLK_I);
        check({de, sp}, 2'h2);
        for (n = 0; n < 40 && ind !== 1'b1; n++) @(negedge CLK_I);
        for (n = 0; n < 40 && ind !== 1'b0; n++) @(negedge CLK_I);
        for (n = 0; n < 40 && ind !== 1'b1; n++) @(negedge CLK_I);
        check(n, BH * CPM);
        check(rdy, 0);
        $display("diagnosis fault test done");
    endtask : t_fault
    task automatic t_start;
        int n;
        do_reset(1'b1, 1'b0);
        repeat (30) @(negedge CLK_I);
        check({sp, rdy}, 2'h0);
        start = 1'b1;
        @(negedge CLK_I);
        start = 1'b0;
        @(negedge CLK_I);
        check(sp, 1);
        wait_ready(n);
        check(n > RDY * CPM - 4 && n < RDY * CPM + 8, 1);
        $display("start command test done");
    endtask : t_start
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        #20000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        t_default();
        t_fault();
        t_start();
        tally_and_finish();
    end
endmodule : test_powerup_status_indicator
`default_nettype wire
